// File: logic/qsw_params.svh
`ifndef QSW_PARAMS_SVH
`define QSW_PARAMS_SVH

`define QSW_PTR_W          4
`define QSW_DEPTH          16
`define QSW_WORD_W         16
`define QSW_CMD_W          8
`define QSW_CMD_PCS_LSB    0
`define QSW_CMD_LENGTH_SELECT_PER_COMMAND      4
`define QSW_CMD_CONT       5
`define QSW_WRAP_PTR       4'h0
`define QSW_LEN_DEFAULT    5'h08
`define QSW_LEN_MAX        5'h10
`define QSW_PORT_DATA_RST  4'h0
`define QSW_SYNC_RST       4'hF
`define QSW_SCK_HALF_NS    40
`define QSW_CLK_PERIOD_NS  5
`define QSW_SCK_HALF_CYC   (`QSW_SCK_HALF_NS / `QSW_CLK_PERIOD_NS)

`endif

// File: logic/qsw_pkg.sv
package qsw_pkg;
    typedef enum logic [1:0] {M_IDLE, M_LOAD, M_SHIFT, M_GAP} qsw_mst_state_t;
    typedef logic [3:0]  qsw_ptr_t;
    typedef logic [15:0] qsw_word_t;
    typedef logic [4:0]  qsw_len_t;
endpackage

// File: logic/qsw_shift_if.sv
`timescale 1ns/10ps
interface qsw_shift_if;
    import qsw_pkg::*;
    logic      load;
    qsw_word_t load_word;
    qsw_len_t  len;
    logic      sample;
    logic      shift;
    logic      in_bit;
    logic      out_bit;
    logic      armed;
    qsw_len_t  bit_cnt;
    qsw_word_t rx_word;
    modport core (output load, load_word, len, sample, shift, in_bit,
                  input out_bit, armed, bit_cnt, rx_word);
    modport shifter (input load, load_word, len, sample, shift, in_bit,
                     output out_bit, armed, bit_cnt, rx_word);
endinterface

// File: logic/qsw_sync.sv
`timescale 1ns/10ps
`include "qsw_params.svh"
module qsw_sync (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       ce_in,
    // pins and filtered levels
    input  wire logic [3:0] pins_in,
    output logic      [3:0] level_out
);
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] level_q;
    wire  [3:0] agree = s2_q ~^ s3_q;

    // a change only counts once the second and third stages agree
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_q    <= `QSW_SYNC_RST;
            s2_q    <= `QSW_SYNC_RST;
            s3_q    <= `QSW_SYNC_RST;
            level_q <= `QSW_SYNC_RST;
        end else if (ce_in) begin
            s1_q    <= pins_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= (s3_q & agree) | (level_q & ~agree);
        end
    end

    assign level_out = level_q;
endmodule // qsw_sync

// File: logic/qsw_shifter.sv
`timescale 1ns/10ps
`include "qsw_params.svh"
module qsw_shifter import qsw_pkg::*; (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic ce_in,
    // strobes and data from the sequencer
    qsw_shift_if.shifter sh
);
    qsw_word_t sr_q;
    qsw_len_t  cnt_q;
    logic      hold_q;
    logic      armed_q;
    wire  [4:0] gap     = 5'h10 - sh.len;
    wire qsw_word_t aligned = sh.load_word << gap;
    wire qsw_word_t mask    = 16'hFFFF >> gap;

    // msb first: the word sits left aligned so bit 15 is always the next out
    assign sh.out_bit = sr_q[15];
    assign sh.bit_cnt = cnt_q;
    assign sh.armed   = armed_q;
    assign sh.rx_word = {sr_q[14:0], sh.in_bit} & mask;

    // a shift only follows a sample, so a trailing edge left over from the
    // previous word cannot disturb a freshly loaded one
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sr_q    <= 16'h0000;
            cnt_q   <= 5'h00;
            hold_q  <= 1'b0;
            armed_q <= 1'b0;
        end else if (ce_in) begin
            if (sh.load) begin
                sr_q    <= aligned;
                cnt_q   <= 5'h00;
                armed_q <= 1'b0;
            end else if (sh.sample) begin
                hold_q  <= sh.in_bit;
                cnt_q   <= cnt_q + 5'h01;
                armed_q <= 1'b1;
            end else if (sh.shift && armed_q) begin
                sr_q    <= {sr_q[14:0], hold_q};
                armed_q <= 1'b0;
            end
        end
    end
endmodule // qsw_shifter

// File: logic/qsw_core.sv
`timescale 1ns/10ps
`include "qsw_params.svh"
// What this block does
// - wrap enabled: after queue end restart at zero or new pointer, per target bit
// - wrapping keeps cycling while irq pending; serial enable stays set
// - wrapped passes overwrite the same receive memory entries
// - end flag set every queue end, sticky until cleared; clear drops irq
// - irq enable is buffered: clearing it blocks new requests only
// - wrap cleared: next queue end sets flag, clears serial enable, stops
// - halt finishes the current transfer then stops; software clears enable after
// - master select clear: slave, never starts a transfer itself
// - slave drives miso, takes mosi and sck, select pin is input only
// - slave select low starts at new pointer, rx stored, tx shifted together
// - slave ignores commands, baud, delays; drives no clock or chip select
// - slave length always from bits field, at most 16
// - full slave word: save completed pointer, step pointer, load next tx
// - one bit per clock; early select rise resumes same entry next time
// - over 16 bits with select low advances and continues
// - slave queue end sets flag, irq if enabled, stops unless wrapping
// - slave wrap uses the same bits and behaves as master wrap
// - master drives chip selects to each command's chip select bits
// - select pin low while master, with pin direction bit 0 clear, raises a mode fault
// - port data bits reset to zero: idle low, active high selects
// - bits field 0000 is 16, 1000..1111 is 8..15, others reserved
module qsw_core import qsw_pkg::*; (
    // clock, reset, enable
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       ce_in,
    // configuration and control
    input  wire logic       master_select_in,
    input  wire logic       cpol_in,
    input  wire logic       serial_enable_set_in,
    input  wire logic       serial_enable_clr_in,
    input  wire logic       wrap_enable_in,
    input  wire logic       wrap_target_select_in,
    input  wire logic       halt_in,
    input  wire logic [3:0] bits_field_in,
    input  wire logic [3:0] end_queue_pointer_in,
    input  wire logic       new_queue_pointer_wr_in,
    input  wire logic [3:0] new_queue_pointer_in,
    input  wire logic       end_of_queue_irq_enable_in,
    input  wire logic       end_of_queue_flag_clr_in,
    input  wire logic       mode_fault_clr_in,
    input  wire logic       port_data_wr_in,
    input  wire logic [3:0] port_data_in,
    input  wire logic [3:0] pin_direction_in,
    // queue memories
    input  wire logic [3:0] mem_addr_in,
    input  wire logic       tx_wr_in,
    input  wire logic       cmd_wr_in,
    input  wire logic [15:0] mem_wdata_in,
    input  wire logic [3:0] rx_rd_addr_in,
    output logic      [15:0] rx_rdata_out,
    // status
    output logic            serial_enable_out,
    output logic            end_of_queue_flag_out,
    output logic            irq_out,
    output logic            mode_fault_out,
    output logic            halted_out,
    output logic      [3:0] completed_queue_pointer_out,
    output logic      [3:0] port_data_out,
    // serial pins
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe_out,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe_out,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe_out,
    input  wire logic       slave_select_n_in,
    output logic      [3:0] pcs_out,
    output logic      [3:0] pcs_oe_out
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic qsw_len_t len_dec(input logic [3:0] b);
        len_dec = b[3] ? {2'h1, b[2:0]} : `QSW_LEN_MAX;
    endfunction

    qsw_word_t       tx_mem  [`QSW_DEPTH];
    qsw_word_t       rx_mem  [`QSW_DEPTH];
    logic [7:0]      cmd_mem [`QSW_DEPTH];
    qsw_ptr_t        wp_q, nqp_q, completed_queue_pointer_q;
    logic            nqp_pend_q, se_q, eoq_q, irq_q, mf_q, halted_q;
    logic [3:0]      port_data_q, pcs_q;
    logic [7:0]      cur_cmd_q, tmr_q;
    logic            sck_q, sck_prev_q, ss_low_prev_q, done_seen_q;
    qsw_word_t       rx_rdata_q;
    qsw_mst_state_t  m_q, m_d;
    logic [3:0]      lv;

    qsw_shift_if sh ();
    qsw_sync u_sync (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .ce_in     (ce_in),
        .pins_in   ({slave_select_n_in, miso_in, mosi_in, sck_in}),
        .level_out (lv)
    );
    qsw_shifter u_shift (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .ce_in   (ce_in),
        .sh      (sh)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire       ss_low    = ~lv[3];
    wire       sck_ph    = lv[0] ^ cpol_in;
    wire       slave_en  = se_q & ~master_select_in;
    wire       s_halted  = halt_in & (sh.bit_cnt == 5'h00) & ~sh.armed;
    wire       s_act     = slave_en & ss_low & ~s_halted;
    wire       s_lead    = s_act & sck_ph & ~sck_prev_q;
    wire       s_trail   = s_act & ~sck_ph & sck_prev_q;
    wire       s_start   = slave_en & ss_low & ~ss_low_prev_q;
    wire       tmr_zero  = (tmr_q == 8'h00);
    wire       m_go      = se_q & master_select_in & ~halt_in;
    wire       m_start   = m_go & ((m_q == M_IDLE) | ((m_q == M_GAP) & tmr_zero));
    wire       m_edge    = (m_q == M_SHIFT) & tmr_zero;
    wire       m_lead    = m_edge & (sck_q == cpol_in);
    wire       m_trail   = m_edge & (sck_q != cpol_in);
    wire       m_abort   = ~master_select_in | serial_enable_clr_in;
    wire       begin_ev  = m_start | s_start;
    wire qsw_ptr_t start_ptr = nqp_pend_q ? nqp_q : wp_q;
    wire qsw_ptr_t wrap_tgt  = wrap_target_select_in ? nqp_q : `QSW_WRAP_PTR;
    wire       at_end    = (wp_q == end_queue_pointer_in);
    wire       done_ev   = sh.sample & (sh.bit_cnt == sh.len - 5'h01);
    wire       eoq_set   = done_ev & at_end;
    wire       stop_ev   = eoq_set & ~wrap_enable_in;
    wire qsw_ptr_t wp_next = nqp_pend_q ? nqp_q :
                             at_end ? (wrap_enable_in ? wrap_tgt : wp_q) :
                             wp_q + 4'h1;
    wire       eoq_d     = eoq_set | (eoq_q & ~end_of_queue_flag_clr_in);
    wire       mf_set    = master_select_in & ~pin_direction_in[0] & ss_low;
    wire [7:0] half_m1   = 8'(`QSW_SCK_HALF_CYC - 1);

    // master length honours the per-command option; slave uses bits field only
    assign sh.len = (master_select_in && !cur_cmd_q[`QSW_CMD_LENGTH_SELECT_PER_COMMAND]) ?
                    `QSW_LEN_DEFAULT : len_dec(bits_field_in);
    assign sh.sample    = m_lead | s_lead;
    assign sh.shift     = m_trail | s_trail;
    assign sh.in_bit    = master_select_in ? lv[2] : lv[1];
    assign sh.load      = begin_ev | done_ev;
    assign sh.load_word = begin_ev ? tx_mem[start_ptr] : tx_mem[wp_next];

    ////////////////////////////////////////////////////////////////////////////
    // memories: software fills tx and commands, wrapped passes overwrite rx
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            if (tx_wr_in)
                tx_mem[mem_addr_in] <= mem_wdata_in;
            if (cmd_wr_in)
                cmd_mem[mem_addr_in] <= mem_wdata_in[7:0];
            if (done_ev)
                rx_mem[wp_q] <= sh.rx_word;
            rx_rdata_q <= rx_mem[rx_rd_addr_in];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // queue pointers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wp_q       <= 4'h0;
            nqp_q      <= 4'h0;
            completed_queue_pointer_q    <= 4'h0;
            nqp_pend_q <= 1'b0;
        end else if (ce_in) begin
            if (new_queue_pointer_wr_in)
                nqp_q <= new_queue_pointer_in;
            if (begin_ev)
                wp_q <= start_ptr;
            else if (done_ev) begin
                wp_q    <= wp_next;
                completed_queue_pointer_q <= wp_q;
            end
            // a write landing with its consumption is kept for the next start
            nqp_pend_q <= new_queue_pointer_wr_in | (serial_enable_set_in & ~se_q)
                          | (nqp_pend_q & ~begin_ev & ~done_ev);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable, flags and request
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            se_q        <= 1'b0;
            eoq_q       <= 1'b0;
            irq_q       <= 1'b0;
            mf_q        <= 1'b0;
            halted_q    <= 1'b0;
            port_data_q <= `QSW_PORT_DATA_RST;
        end else if (ce_in) begin
            if (serial_enable_set_in)
                se_q <= 1'b1;
            else if (serial_enable_clr_in || stop_ev)
                se_q <= 1'b0;
            eoq_q    <= eoq_d;
            irq_q    <= eoq_d & (irq_q | end_of_queue_irq_enable_in);
            mf_q     <= mf_set | (mf_q & ~mode_fault_clr_in);
            halted_q <= halt_in & (master_select_in ? (m_q == M_IDLE) : s_halted);
            if (port_data_wr_in)
                port_data_q <= port_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // master sequencer; slave mode never leaves idle
    always_comb begin
        m_d = m_q;
        case (m_q)
            M_IDLE:  if (m_start) m_d = M_LOAD;
            M_LOAD:  if (tmr_zero) m_d = M_SHIFT;
            M_SHIFT: if (m_trail && done_seen_q) m_d = M_GAP;
            M_GAP:   if (tmr_zero) m_d = m_start ? M_LOAD : M_IDLE;
            default: m_d = M_IDLE;
        endcase
        if (m_abort)
            m_d = M_IDLE;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            m_q         <= M_IDLE;
            tmr_q       <= 8'h00;
            sck_q       <= 1'b0;
            done_seen_q <= 1'b0;
            cur_cmd_q   <= 8'h00;
        end else if (ce_in) begin
            m_q         <= m_d;
            tmr_q       <= (tmr_zero || m_q == M_IDLE) ? half_m1 : tmr_q - 8'h01;
            sck_q       <= (m_q == M_SHIFT) ? (sck_q ^ tmr_zero) : cpol_in;
            done_seen_q <= (done_seen_q | (done_ev & master_select_in)) & ~m_start;
            if (m_start)
                cur_cmd_q <= cmd_mem[start_ptr];
        end
    end

    // chip selects hold their pattern between words only when cont is set
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pcs_q         <= `QSW_PORT_DATA_RST;
            // start from the synchronised level so reset cannot fake an edge
            sck_prev_q    <= sck_ph;
            ss_low_prev_q <= 1'b0;
        end else if (ce_in) begin
            if (m_start)
                pcs_q <= cmd_mem[start_ptr][`QSW_CMD_PCS_LSB +: 4];
            else if (m_q == M_IDLE || (m_q == M_GAP && !cur_cmd_q[`QSW_CMD_CONT]))
                pcs_q <= port_data_q;
            sck_prev_q    <= sck_ph;
            ss_low_prev_q <= ss_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins: slave drives only miso, and only while selected
    assign sck_out     = sck_q;
    assign sck_oe_out  = master_select_in;
    assign mosi_out    = sh.out_bit;
    assign mosi_oe_out = master_select_in;
    assign miso_out    = sh.out_bit;
    assign miso_oe_out = slave_en & ss_low;
    assign pcs_out     = pcs_q;
    assign pcs_oe_out  = master_select_in ? pin_direction_in : 4'h0;
    assign rx_rdata_out          = rx_rdata_q;
    assign serial_enable_out     = se_q;
    assign end_of_queue_flag_out = eoq_q;
    assign irq_out               = irq_q;
    assign mode_fault_out        = mf_q;
    assign halted_out            = halted_q;
    assign completed_queue_pointer_out = completed_queue_pointer_q;
    assign port_data_out         = port_data_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    property p_wrap_ptr;
        ce_in && eoq_set && wrap_enable_in && !nqp_pend_q && !begin_ev
            |=> wp_q == $past(wrap_tgt);
    endproperty
    a_wrap_ptr: assert property (p_wrap_ptr) else $error("wrap pointer wrong");
    property p_wrap_keeps_enable;
        ce_in && eoq_set && wrap_enable_in && !serial_enable_clr_in |=> se_q;
    endproperty
    a_wrap_keeps_enable: assert property (p_wrap_keeps_enable)
        else $error("enable dropped in wrap");
    property p_rx_store;
        ce_in && done_ev |=> rx_mem[$past(wp_q)] == $past(sh.rx_word);
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("rx word not stored");
    property p_eoq_set;
        ce_in && eoq_set |=> eoq_q;
    endproperty
    a_eoq_set: assert property (p_eoq_set) else $error("end flag not set");
    property p_irq_withdraw;
        ce_in && end_of_queue_flag_clr_in && !eoq_set |=> !irq_q && !eoq_q;
    endproperty
    a_irq_withdraw: assert property (p_irq_withdraw) else $error("irq kept");
    property p_irq_buffered;
        ce_in && irq_q && !end_of_queue_flag_clr_in |=> irq_q;
    endproperty
    a_irq_buffered: assert property (p_irq_buffered) else $error("irq lost");
    property p_stop_at_end;
        ce_in && stop_ev && !serial_enable_set_in |=> !se_q ##1 !s_act;
    endproperty
    a_stop_at_end: assert property (p_stop_at_end) else $error("no stop");
    property p_slave_idle;
        ce_in && !master_select_in
            |-> (!sck_oe_out && pcs_oe_out == 4'h0) ##1 (m_q == M_IDLE);
    endproperty
    a_slave_idle: assert property (p_slave_idle) else $error("slave started");
    property p_step;
        ce_in && done_ev && !at_end && !nqp_pend_q && !begin_ev
            |=> wp_q == $past(wp_q) + 4'h1 && completed_queue_pointer_q == $past(wp_q);
    endproperty
    a_step: assert property (p_step) else $error("pointer step wrong");
    property p_mode_fault;
        ce_in && mf_set |=> mf_q [*2];
    endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("fault lost");

    c_wrap:  cover property (ce_in && eoq_set && wrap_enable_in);
    c_slave: cover property (ce_in && done_ev && !master_select_in);
    c_fault: cover property (ce_in && mf_set);
endmodule // qsw_core

// File: verif/qsw_spi_master.sv
`timescale 1ns/10ps
module qsw_spi_master (
    // serial lines toward the slave
    output logic      sck_out,
    output logic      mosi_out,
    output logic      ss_n_out,
    input  wire logic miso_in
);
    initial begin
        sck_out  = 1'b0;
        mosi_out = 1'b1;
        ss_n_out = 1'b1;
    end
    // n bits msb first, sampled on the rising edge; clock stands still outside frames
    task automatic xfer(input int n, input logic [47:0] tx, input logic drop,
                        output logic [47:0] rx);
        rx = '0;
        ss_n_out = 1'b0;
        #100;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_out = tx[i];
            #62.5;
            rx[i] = miso_in;
            sck_out = 1'b1;
            #62.5;
            sck_out = 1'b0;
        end
        // a released data line must not keep showing the last bit
        mosi_out = ~mosi_out;
        if (drop) begin
            ss_n_out = 1'b1;
        end
        #100;
    endtask
endmodule // qsw_spi_master

// File: verif/queued_spi_wrap_slave_cs_test.sv
`timescale 1ns/10ps
module queued_spi_wrap_slave_cs_test;
    import qsw_pkg::*;
    logic        clk_in, srst_in, ms, se_set, se_clr, wr_en, wr_tgt, nqp_wr, ie, fl_clr;
    logic        mf_clr, pd_wr, tx_wr, cmd_wr, sck, mosi, ss_n, se_o, fl_o, irq_o, mf_o;
    logic        hlt_o, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, hlt;
    logic [3:0]  bits_f, eqp, nqp, pdat, pdir, addr, rd_addr, cptr, pd_o, peripheral_chip_select, pcs_oe;
    logic [15:0] wdata, rdata;
    logic [47:0] rx;
    logic [31:0] seed = 32'h59;
    qsw_word_t   txm [16];
    qsw_word_t   exp_rx [16];
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    qsw_core qsw_core_inst (
        .clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .master_select_in(ms),
        .cpol_in(1'b0), .serial_enable_set_in(se_set), .serial_enable_clr_in(se_clr),
        .wrap_enable_in(wr_en), .wrap_target_select_in(wr_tgt), .halt_in(hlt),
        .bits_field_in(bits_f), .end_queue_pointer_in(eqp), .new_queue_pointer_wr_in(nqp_wr),
        .new_queue_pointer_in(nqp), .end_of_queue_irq_enable_in(ie),
        .end_of_queue_flag_clr_in(fl_clr), .mode_fault_clr_in(mf_clr),
        .port_data_wr_in(pd_wr), .port_data_in(pdat), .pin_direction_in(pdir),
        .mem_addr_in(addr), .tx_wr_in(tx_wr), .cmd_wr_in(cmd_wr), .mem_wdata_in(wdata),
        .rx_rd_addr_in(rd_addr), .rx_rdata_out(rdata), .serial_enable_out(se_o),
        .end_of_queue_flag_out(fl_o), .irq_out(irq_o), .mode_fault_out(mf_o),
        .halted_out(hlt_o), .completed_queue_pointer_out(cptr), .port_data_out(pd_o),
        .sck_in(sck), .sck_out(sck_o), .sck_oe_out(sck_oe), .mosi_in(mosi),
        .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_in(1'b0), .miso_out(miso_o),
        .miso_oe_out(miso_oe), .slave_select_n_in(ss_n), .pcs_out(peripheral_chip_select), .pcs_oe_out(pcs_oe)
    );
    qsw_spi_master qsw_spi_master_inst (
        .sck_out(sck), .mosi_out(mosi), .ss_n_out(ss_n), .miso_in(miso_o)
    );

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_in) s = 1'b1;
        @(negedge clk_in) s = 1'b0;
    endtask
    // one queue entry of len bits; miso is only judged when select toggles per word
    task automatic word(input int p, input int len, input logic drop);
        logic [47:0] tx;
        int m;
        m = (1 << len) - 1;
        tx = 48'(xs() & m);
        qsw_spi_master_inst.xfer(len, tx, drop, rx);
        exp_rx[p] = 16'(tx);
        if (drop) chk(rx[15:0], txm[p] & m[15:0]);
        chk(cptr, 4'(p));
    endtask
    task automatic rdchk(input int p);
        @(negedge clk_in) rd_addr = 4'(p);
        repeat (2) @(negedge clk_in);
        chk(rdata, exp_rx[p]);
    endtask

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            $display("mismatch at %0t: run did not finish", $time);
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {ms, se_set, se_clr, wr_en, wr_tgt, nqp_wr, ie, fl_clr, mf_clr, pd_wr, hlt} = '0;
        {tx_wr, cmd_wr, bits_f, eqp, nqp, pdat, pdir, addr, rd_addr, wdata} = '0;
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        chk(pd_o, 4'h0);
        chk({se_o, fl_o, mf_o}, 3'h0);
        for (int i = 0; i < 16; i++) begin
            @(negedge clk_in) addr = 4'(i);
            wdata = 16'(xs());
            txm[i] = wdata;
            tx_wr = 1'b1;
        end
        @(negedge clk_in) tx_wr = 1'b0;
        // slave queue of four 8-bit words, select toggled between words
        bits_f = 4'h8;
        eqp = 4'h3;
        ie = 1'b1;
        pulse(nqp_wr);
        pulse(se_set);
        for (int p = 0; p < 4; p++) word(p, 8, 1'b1);
        chk({se_o, fl_o, irq_o}, 3'h3);
        @(negedge clk_in) ie = 1'b0;
        @(negedge clk_in);
        chk(irq_o, 1'b1);
        pulse(fl_clr);
        @(negedge clk_in);
        chk({fl_o, irq_o}, 2'h0);
        for (int p = 0; p < 4; p++) rdchk(p);
        // early select rise resumes the same entry
        nqp = 4'h2;
        eqp = 4'h2;
        bits_f = 4'hC;
        pulse(nqp_wr);
        pulse(se_set);
        qsw_spi_master_inst.xfer(5, 48'h15, 1'b1, rx);
        chk(cptr, 4'h3);
        word(2, 12, 1'b1);
        rdchk(2);
        chk(se_o, 1'b0);
        // wrap with select held low, 16-bit words, both wrap targets
        bits_f = 4'h0;
        wr_en = 1'b1;
        for (int t = 0; t < 2; t++) begin
            nqp = 4'(t);
            eqp = 4'(t + 1);
            wr_tgt = t[0];
            pulse(nqp_wr);
            pulse(se_set);
            pulse(fl_clr);
            word(t, 16, 1'b0);
            chk({miso_oe, sck_oe, mosi_oe, pcs_oe}, 7'h40);
            word(t + 1, 16, 1'b0);
            word(t, 16, 1'b0);
            chk({se_o, fl_o}, 2'h3);
            pulse(fl_clr);
            @(negedge clk_in) wr_en = 1'b0;
            word(t + 1, 16, 1'b1);
            chk({se_o, fl_o}, 2'h1);
            rdchk(t);
            wr_en = 1'b1;
        end
        // master: command selects drive the chip selects, port data idle zero
        ms = 1'b1;
        wr_en = 1'b0;
        pdir = 4'hE;
        eqp = 4'h1;
        nqp = 4'h0;
        wdata = 16'h000A;
        pulse(nqp_wr);
        for (int i = 0; i < 2; i++) begin
            addr = 4'(i);
            pulse(cmd_wr);
        end
        pulse(se_set);
        repeat (6) @(negedge clk_in);
        chk(peripheral_chip_select, 4'hA);
        chk({sck_o, mosi_o}, {1'b0, txm[0][7]});
        chk({sck_oe, mosi_oe, miso_oe, pcs_oe}, 7'h6E);
        // halt mid word: that word completes, the second entry waits
        hlt = 1'b1;
        for (int i = 0; i < 400 && hlt_o !== 1'b1; i++) @(negedge clk_in);
        chk({se_o, hlt_o, cptr, peripheral_chip_select}, 10'h300);
        hlt = 1'b0;
        for (int i = 0; i < 400 && se_o !== 1'b0; i++) @(negedge clk_in);
        repeat (24) @(negedge clk_in);
        chk({se_o, cptr, peripheral_chip_select}, 9'h010);
        // a select low while master raises a sticky fault
        pdir = 4'h0;
        qsw_spi_master_inst.ss_n_out = 1'b0;
        repeat (10) @(negedge clk_in);
        qsw_spi_master_inst.ss_n_out = 1'b1;
        repeat (10) @(negedge clk_in);
        chk(mf_o, 1'b1);
        pulse(mf_clr);
        @(negedge clk_in);
        chk(mf_o, 1'b0);
        end_sim();
    end
endmodule // queued_spi_wrap_slave_cs_test
